// *** ecc_pkg.sv ***
// Constants, field layouts and types for the event capture counter block.
// Assumes one 100 MHz core clock and a plain strobe register port.
package ecc_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ECC_ADDR_CAPTURE_CFG = 8'h00;
   localparam logic [7:0] ECC_ADDR_COUNT = 8'h04;
   localparam logic [7:0] ECC_ADDR_BEGIN_CAP = 8'h08;
   localparam logic [7:0] ECC_ADDR_END_CAP = 8'h0C;
   localparam logic [7:0] ECC_ADDR_LIMIT = 8'h10;
   localparam logic [7:0] ECC_ADDR_SYNC_CFG = 8'h14;
   localparam logic [7:0] ECC_ADDR_GLOBAL_SYNC = 8'h18;
   localparam logic [7:0] ECC_ADDR_PRESCALE = 8'h1C;
   localparam logic [7:0] ECC_ADDR_CHAN_CFG = 8'h20;
   localparam logic [7:0] ECC_ADDR_OUT_LEVEL = 8'h24;
   localparam logic [7:0] ECC_ADDR_STATUS = 8'h28;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ECC_CHAN_CFG_STATE_BIT = 5;
   localparam int ECC_CHAN_CFG_OUT_BIT = 6;

   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [15:0] ECC_LIMIT_DEFAULT = 16'hFFFF;
   localparam logic [15:0] ECC_PRESCALE_RESET = 16'h0009;
   localparam logic [15:0] ECC_EARLY_END_COUNT = 16'h0001;
   localparam logic [15:0] ECC_COUNT_ZERO = 16'h0000;
   localparam logic [15:0] ECC_COUNT_ONE = 16'h0001;
   localparam int ECC_NUM_CH = 32;
   // Global sync pulse length in clocks; must outlast the pin filter
   localparam int ECC_GSYNC_WIDTH = 4;

   // ---------------------------------------------------------------
   // Modes and edges
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      capture_mode_free_run = 2'h0,
      capture_mode_start_stop = 2'h1,
      capture_mode_until_stop = 2'h2,
      capture_mode_level_gated = 2'h3
   } ecc_mode_e;

   // In level gated mode the primary edge field holds the gate level:
   // 0 means gate_active_high, 1 means gate_active_low
   typedef enum logic [1:0] {
      event_edge_rising = 2'h0,
      event_edge_falling = 2'h1,
      event_edge_any = 2'h2
   } ecc_edge_e;

   typedef enum logic [1:0] {
      sync_edge_off = 2'h0,
      sync_edge_rising = 2'h1,
      sync_edge_falling = 2'h2,
      sync_edge_any = 2'h3
   } ecc_sync_edge_e;

   typedef enum logic [2:0] {
      ST_ARMED = 3'b001,
      ST_COUNTING = 3'b010,
      ST_EARLY_END = 3'b100
   } ecc_state_e;

   // ---------------------------------------------------------------
   // Configuration words
   // ---------------------------------------------------------------
   typedef struct packed {
      logic keep_wrap_value;          // bit 18
      logic use_divided_clock;        // bit 17
      logic single_input_start_stop;  // bit 16
      ecc_edge_e sec_edge;            // bits 15:14
      logic [4:0] sec_ch;             // bits 13:9
      logic [4:0] prim_ch;            // bits 8:4
      ecc_edge_e prim_edge;           // bits 3:2
      ecc_mode_e mode;                // bits 1:0
   } ecc_cap_cfg_s;

   typedef struct packed {
      ecc_sync_edge_e edge_sel;       // bits 7:6
      logic [4:0] src_ch;             // bits 5:1
      logic src_global;               // bit 0
   } ecc_sync_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ecc_bus_req_s;

endpackage

// *** ecc_event_capture_counter.sv ***
// Event capture counter block with sync, limit and sinking outputs.
// Assumes pins and global sync arrive asynchronously and the register
// master follows the one-cycle strobe protocol.
//
// Behaviour
// - Counter runs gated; captures on begin and end
// - Free-run mode counts every enabled tick
// - Start-stop and until-stop modes bound counting
// - Level-gated mode counts while gate active
// - Early end: capture end 1, begin 0/1
// - Begin detector fires rising, falling or any
// - Gate level high or low, gated mode
// - Primary input is end in until-stop
// - Secondary input by 5-bit index, edge selectable
// - Single-input option uses primary for both
// - Config flags: divided clock, keep wrap
// - Without keep flag limit loads FFFF
// - Count readable without disturbing counting
// - Begin and end captures readable separately
// - Software reset command clears count
// - New limit acts at overflow or reset
// - Sync source global or channel, edge selectable
// - Sync aligned to block clock tick
// - Global sync command emits one pulse
// - Sinking output: 0 pulls low, 1 floats
// - Output config loads initial level
// - Level writes only hit output channels
// - Sync event resets block counter
`timescale 1ns/1ps

module ecc_event_capture_counter
   import ecc_pkg::*;
#(
   parameter int NUM_CH = ECC_NUM_CH
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire ecc_bus_req_s reg_req,
   output logic [31:0] reg_rdata,
   input wire logic [NUM_CH-1:0] chan_in,
   output logic [NUM_CH-1:0] chan_out,
   output logic [NUM_CH-1:0] chan_oe_n,
   input wire logic global_sync_in,
   output logic global_sync_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH:0] sync1;
      logic [NUM_CH:0] sync2;
      logic [NUM_CH:0] sync3;
      logic [NUM_CH:0] filt;
      logic [NUM_CH:0] filt_prev;
      ecc_cap_cfg_s cap_cfg;
      ecc_sync_cfg_s sync_cfg;
      ecc_state_e state;
      logic [15:0] count;
      logic [15:0] begin_cap;
      logic [15:0] end_cap;
      logic [15:0] limit_reg;
      logic limit_pending;
      logic [15:0] limit_active;
      logic [15:0] prescale;
      logic [15:0] pre_cnt;
      logic sync_pending;
      logic [NUM_CH-1:0] out_func;
      logic [NUM_CH-1:0] out_level;
      logic refused;
      logic gsync_pulse;
      logic [2:0] gsync_left;
      logic [31:0] rdata;
   } ecc_regs_s;

   ecc_regs_s r;
   ecc_regs_s next_r;

   function automatic logic edge_hit(ecc_edge_e e, logic cur, logic prev);
      logic hit;
      hit = 1'b0;
      case (e)
         event_edge_rising: hit = cur & ~prev;
         event_edge_falling: hit = ~cur & prev;
         event_edge_any: hit = cur ^ prev;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ---------------------------------------------------------------
   // Combinational next state
   // ---------------------------------------------------------------
   logic [NUM_CH:0] changing;
   logic tick;
   logic prim_cur;
   logic prim_prev;
   logic sec_cur;
   logic sec_prev;
   logic prim_evt;
   logic sec_evt;
   logic begin_evt;
   logic end_evt;
   logic begin_fell;
   logic gate_on;
   logic run;
   logic sync_cur;
   logic sync_prev;
   logic sync_evt;
   logic sw_reset;
   logic clear_cnt;
   logic wr_cfg;
   logic [4:0] sec_sel;
   logic [4:0] sync_sel;

   always_comb begin
      next_r = r;

      // Pin synchroniser: a level is accepted once stages 2 and 3 agree
      next_r.sync1 = {global_sync_in, chan_in};
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      changing = r.sync2 ^ r.sync3;
      next_r.filt = (~changing & r.sync3) | (changing & r.filt);
      next_r.filt_prev = r.filt;

      // Divided clock tick
      tick = 1'b1;
      if (r.pre_cnt >= r.prescale) begin
         next_r.pre_cnt = ECC_COUNT_ZERO;
      end else begin
         next_r.pre_cnt = r.pre_cnt + ECC_COUNT_ONE;
      end
      if (r.cap_cfg.use_divided_clock) begin
         tick = (r.pre_cnt >= r.prescale);
      end

      // Event selection
      sec_sel = r.cap_cfg.single_input_start_stop ? r.cap_cfg.prim_ch
         : r.cap_cfg.sec_ch;
      prim_cur = r.filt[r.cap_cfg.prim_ch];
      prim_prev = r.filt_prev[r.cap_cfg.prim_ch];
      sec_cur = r.filt[sec_sel];
      sec_prev = r.filt_prev[sec_sel];
      prim_evt = edge_hit(r.cap_cfg.prim_edge, prim_cur, prim_prev);
      sec_evt = edge_hit(r.cap_cfg.sec_edge, sec_cur, sec_prev);
      if (r.cap_cfg.mode == capture_mode_until_stop) begin
         begin_evt = sec_evt;
         end_evt = prim_evt;
         begin_fell = sec_prev & ~sec_cur;
      end else begin
         begin_evt = prim_evt;
         end_evt = sec_evt;
         begin_fell = prim_prev & ~prim_cur;
      end
      // Gate level: edge field bit 0 clear means active high
      gate_on = r.cap_cfg.prim_edge[0] ? ~prim_cur : prim_cur;

      // Sync source and edge
      sync_sel = r.sync_cfg.src_ch;
      sync_cur = r.sync_cfg.src_global ? r.filt[NUM_CH] : r.filt[sync_sel];
      sync_prev = r.sync_cfg.src_global ? r.filt_prev[NUM_CH]
         : r.filt_prev[sync_sel];
      case (r.sync_cfg.edge_sel)
         sync_edge_rising: sync_evt = sync_cur & ~sync_prev;
         sync_edge_falling: sync_evt = ~sync_cur & sync_prev;
         sync_edge_any: sync_evt = sync_cur ^ sync_prev;
         default: sync_evt = 1'b0;
      endcase
      // Sync waits for the block's own tick, so blocks may differ by one
      next_r.sync_pending = (r.sync_pending | sync_evt) & ~tick;

      // Bus decode
      sw_reset = reg_req.wr && reg_req.addr == ECC_ADDR_COUNT;
      wr_cfg = reg_req.wr && reg_req.addr == ECC_ADDR_CAPTURE_CFG;
      clear_cnt = sw_reset | (tick & (r.sync_pending | sync_evt));

      // Capture sequencer
      run = 1'b0;
      case (r.cap_cfg.mode)
         capture_mode_free_run: begin
            run = 1'b1;
            if (begin_evt) begin
               next_r.begin_cap = r.count;
            end
            if (end_evt) begin
               next_r.end_cap = r.count;
            end
         end
         capture_mode_level_gated: begin
            run = gate_on;
            if (gate_on && !(r.cap_cfg.prim_edge[0] ? ~prim_prev
                  : prim_prev)) begin
               next_r.begin_cap = r.count;
            end
            if (end_evt) begin
               next_r.end_cap = r.count;
            end
         end
         default: begin
            case (r.state)
               ST_ARMED: begin
                  if (begin_evt) begin
                     // The begin cycle counts, so end minus begin is the span
                     run = 1'b1;
                     next_r.begin_cap = r.count;
                     next_r.state = ST_COUNTING;
                  end else if (end_evt) begin
                     next_r.state = ST_EARLY_END;
                  end
               end
               ST_COUNTING: begin
                  run = 1'b1;
                  if (end_evt) begin
                     next_r.end_cap = r.count;
                     next_r.state = ST_ARMED;
                  end
               end
               ST_EARLY_END: begin
                  if (begin_evt) begin
                     // Starts and stops on the same begin event
                     next_r.begin_cap = begin_fell ? ECC_COUNT_ONE
                        : ECC_COUNT_ZERO;
                     next_r.end_cap = ECC_EARLY_END_COUNT;
                     next_r.state = ST_ARMED;
                  end
               end
               default: next_r.state = ST_ARMED;
            endcase
         end
      endcase

      // Counter, wrap and limit hand-over
      if (clear_cnt) begin
         next_r.count = ECC_COUNT_ZERO;
         if (r.limit_pending) begin
            next_r.limit_active = r.limit_reg;
            next_r.limit_pending = 1'b0;
         end
      end else if (run && tick) begin
         if (r.count >= r.limit_active) begin
            next_r.count = ECC_COUNT_ZERO;
            if (r.limit_pending) begin
               next_r.limit_active = r.limit_reg;
               next_r.limit_pending = 1'b0;
            end
         end else begin
            next_r.count = r.count + ECC_COUNT_ONE;
         end
      end

      // Register writes
      // A single-cycle pulse would never pass a three-stage pin filter
      next_r.gsync_pulse = 1'b0;
      if (r.gsync_left != 3'h0) begin
         next_r.gsync_pulse = 1'b1;
         next_r.gsync_left = r.gsync_left - 3'h1;
      end
      if (wr_cfg) begin
         next_r.cap_cfg = ecc_cap_cfg_s'(reg_req.wdata[18:0]);
         // Until-stop counts from configuration until the end event
         next_r.state = (reg_req.wdata[1:0] == capture_mode_until_stop)
            ? ST_COUNTING : ST_ARMED;
         if (!reg_req.wdata[18]) begin
            next_r.limit_reg = ECC_LIMIT_DEFAULT;
            next_r.limit_pending = 1'b1;
         end
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_LIMIT) begin
         next_r.limit_reg = reg_req.wdata[15:0];
         next_r.limit_pending = 1'b1;
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_SYNC_CFG) begin
         next_r.sync_cfg = ecc_sync_cfg_s'(reg_req.wdata[7:0]);
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_GLOBAL_SYNC) begin
         next_r.gsync_pulse = 1'b1;
         next_r.gsync_left = 3'(ECC_GSYNC_WIDTH - 1);
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_PRESCALE) begin
         next_r.prescale = reg_req.wdata[15:0];
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_CHAN_CFG) begin
         next_r.out_func[reg_req.wdata[4:0]] =
            reg_req.wdata[ECC_CHAN_CFG_OUT_BIT];
         next_r.out_level[reg_req.wdata[4:0]] =
            reg_req.wdata[ECC_CHAN_CFG_STATE_BIT];
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_OUT_LEVEL) begin
         // Bits of non-output channels are dropped; one that differs from the held level is flagged
         next_r.out_level = (r.out_func & reg_req.wdata[NUM_CH-1:0])
            | (~r.out_func & r.out_level);
         if (|(~r.out_func & (reg_req.wdata[NUM_CH-1:0] ^ r.out_level))) begin
            next_r.refused = 1'b1;
         end
      end else if (reg_req.wr && reg_req.addr == ECC_ADDR_STATUS) begin
         next_r.refused = 1'b0;
      end

      // Register reads; the read only samples, counting goes on
      next_r.rdata = 32'h0000_0000;
      if (reg_req.rd) begin
         if (reg_req.addr == ECC_ADDR_CAPTURE_CFG) begin
            next_r.rdata = {13'h0000, r.cap_cfg};
         end else if (reg_req.addr == ECC_ADDR_COUNT) begin
            next_r.rdata = {16'h0000, r.count};
         end else if (reg_req.addr == ECC_ADDR_BEGIN_CAP) begin
            next_r.rdata = {16'h0000, r.begin_cap};
         end else if (reg_req.addr == ECC_ADDR_END_CAP) begin
            next_r.rdata = {16'h0000, r.end_cap};
         end else if (reg_req.addr == ECC_ADDR_LIMIT) begin
            next_r.rdata = {16'h0000, r.limit_reg};
         end else if (reg_req.addr == ECC_ADDR_SYNC_CFG) begin
            next_r.rdata = {24'h000000, r.sync_cfg};
         end else if (reg_req.addr == ECC_ADDR_PRESCALE) begin
            next_r.rdata = {16'h0000, r.prescale};
         end else if (reg_req.addr == ECC_ADDR_CHAN_CFG) begin
            next_r.rdata = 32'(r.out_func);
         end else if (reg_req.addr == ECC_ADDR_OUT_LEVEL) begin
            next_r.rdata = 32'(r.out_level);
         end else if (reg_req.addr == ECC_ADDR_STATUS) begin
            next_r.rdata = {29'h0000000, r.state == ST_COUNTING,
               r.limit_pending, r.refused};
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= ST_ARMED;
         r.limit_reg <= ECC_LIMIT_DEFAULT;
         r.limit_active <= ECC_LIMIT_DEFAULT;
         r.prescale <= ECC_PRESCALE_RESET;
         r.out_level <= '1;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Sinking output: level 0 drives low, level 1 releases the pin
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         chan_oe_n <= '1;
         chan_out <= '0;
      end else begin
         chan_oe_n <= ~(next_r.out_func & ~next_r.out_level);
         chan_out <= '0;
      end
   end

   assign reg_rdata = r.rdata;
   assign global_sync_out = r.gsync_pulse;

endmodule

// *** ecc_pin_model.sv ***
// Model of the outside world at the configurable channels and sync wire.
// Assumes the bench sets each source level and the block sinks only.
`timescale 1ns/1ps

module ecc_pin_model #(
   parameter int NUM_CH = 32
) (
   input wire logic [NUM_CH-1:0] pin_drv,
   input wire logic [NUM_CH-1:0] chan_oe_n,
   input wire logic global_sync_out,
   output logic [NUM_CH-1:0] chan_in,
   output logic global_sync_in
);
   // ------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------
   // A sunk pin reads low whatever the outside source drives
   assign chan_in = pin_drv & chan_oe_n;
   // Chip-wide wire, so the pulse returns to the block itself
   assign global_sync_in = global_sync_out;
endmodule

// *** ecc_capture_asserts.sv ***
// Port checker for the event capture counter.
// Assumes it is bound onto ecc_event_capture_counter.
`timescale 1ns/1ps

module ecc_capture_asserts
   import ecc_pkg::*;
#(
   parameter int NUM_CH = ECC_NUM_CH
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire ecc_bus_req_s reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic [NUM_CH-1:0] chan_in,
   input wire logic [NUM_CH-1:0] chan_out,
   input wire logic [NUM_CH-1:0] chan_oe_n,
   input wire logic global_sync_in,
   input wire logic global_sync_out
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_sync_cmd;
      reg_req.wr && reg_req.addr == ECC_ADDR_GLOBAL_SYNC;
   endsequence
   sequence s_level_wr;
      reg_req.wr && reg_req.addr == ECC_ADDR_OUT_LEVEL;
   endsequence
   sequence s_out_cfg;
      reg_req.wr && reg_req.addr == ECC_ADDR_CHAN_CFG && reg_req.wdata[6];
   endsequence

   chk_sync_pulse:
   assert property (s_sync_cmd |-> ##[1:2] global_sync_out)
      else $error("global sync command gave no pulse");
   chk_sync_single:
   assert property ($rose(global_sync_out) |->
      global_sync_out[*4] ##1 !global_sync_out)
      else $error("global sync pulse not four cycles long");
   chk_rdata_idle:
   assert property (!reg_req.rd |=> reg_rdata == 32'h0)
      else $error("read data present without a read");
   chk_unmapped_read:
   assert property (reg_req.rd && reg_req.addr == 8'h30 |=> reg_rdata == 32'h0)
      else $error("unmapped read returned data");
   chk_out_sink:
   assert property (chan_out == '0)
      else $error("channel output drives high");
   chk_cfg_level:
   assert property (s_out_cfg |=>
      chan_oe_n[$past(reg_req.wdata[4:0])] == $past(reg_req.wdata[5]))
      else $error("output setup did not load its level");
   chk_oe_cause:
   assert property ($changed(chan_oe_n) |-> $past(reg_req.wr) &&
      ($past(reg_req.addr) == ECC_ADDR_CHAN_CFG ||
       $past(reg_req.addr) == ECC_ADDR_OUT_LEVEL))
      else $error("output enable changed without a write");
   chk_level_write:
   assert property (s_level_wr |=> ((chan_oe_n ^
      $past(reg_req.wdata[NUM_CH-1:0])) & ~$past(chan_oe_n)) == '0)
      else $error("driven channel ignored its level write");
endmodule

bind ecc_event_capture_counter ecc_capture_asserts #(.NUM_CH(NUM_CH)) u_chk (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .reg_req(reg_req),
   .reg_rdata(reg_rdata),
   .chan_in(chan_in),
   .chan_out(chan_out),
   .chan_oe_n(chan_oe_n),
   .global_sync_in(global_sync_in),
   .global_sync_out(global_sync_out)
);

// *** tb.sv ***
// Self-checking bench for the event capture counter.
// Assumes the pin model closes the open-drain pins and the sync wire.
`timescale 1ns/1ps

module tb;
   import ecc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   ecc_bus_req_s reg_req = '0;
   logic [31:0] reg_rdata, chan_in, chan_out, chan_oe_n;
   logic [31:0] pin_drv = '0;
   logic global_sync_in, global_sync_out;
   logic [31:0] rv, c1, c2;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;
   int idle_tab [3] = '{0, 1, 0};
   logic [31:0] sync_tab [3] = '{32'h41, 32'h84, 32'h0};

   // ------------------------------------------------------------
   // Clock, parts and timeout
   // ------------------------------------------------------------
   always #5 core_clk = ~core_clk;

   ecc_event_capture_counter #(.NUM_CH(32)) DUT (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out),
      .chan_oe_n(chan_oe_n), .global_sync_in(global_sync_in),
      .global_sync_out(global_sync_out));
   ecc_pin_model #(.NUM_CH(32)) u_pins (.pin_drv(pin_drv),
      .chan_oe_n(chan_oe_n), .global_sync_out(global_sync_out),
      .chan_in(chan_in), .global_sync_in(global_sync_in));

   // Whole run is under a thousand cycles; this only cuts a hang
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // An idle edge after each strobe keeps two calls from colliding
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge core_clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      waitc(5);
      sys_rst <= 1'b0;
      waitc(1);
      rd_reg(ECC_ADDR_LIMIT, rv);
      chk("limit", rv, 32'hFFFF);
      rd_reg(8'h30, rv);
      chk("unmapped", rv, 32'h0);
      // Start-stop capture, end from second channel
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h201);
      wr_reg(ECC_ADDR_COUNT, 32'h0);
      pin_drv[0] <= 1'b1;
      waitc(50);
      pin_drv[1] <= 1'b1;
      waitc(10);
      rd_reg(ECC_ADDR_BEGIN_CAP, c1);
      rd_reg(ECC_ADDR_END_CAP, c2);
      chk("capture_gap", c2 - c1, 32'h32);
      rd_reg(ECC_ADDR_COUNT, c1);
      waitc(5);
      rd_reg(ECC_ADDR_COUNT, c2);
      chk("stopped", c2, c1);
      // End before begin, for each begin edge kind
      for (int i = 0; i < 3; i++) begin
         pin_drv[1:0] <= {1'b0, 1'(idle_tab[i])};
         waitc(10);
         wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h201 | 32'(i << 2));
         pin_drv[1] <= 1'b1;
         waitc(10);
         pin_drv[0] <= ~1'(idle_tab[i]);
         waitc(10);
         rd_reg(ECC_ADDR_BEGIN_CAP, rv);
         chk("early_begin", rv, 32'(idle_tab[i]));
         rd_reg(ECC_ADDR_END_CAP, rv);
         chk("early_end", rv, 32'h1);
      end
      // Level gated, active high then active low
      pin_drv[0] <= 1'b0;
      waitc(10);
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h3);
      wr_reg(ECC_ADDR_COUNT, 32'h0);
      rd_reg(ECC_ADDR_COUNT, rv);
      chk("sw_reset", rv, 32'h0);
      pin_drv[0] <= 1'b1;
      waitc(40);
      pin_drv[0] <= 1'b0;
      waitc(10);
      rd_reg(ECC_ADDR_COUNT, c1);
      waitc(20);
      rd_reg(ECC_ADDR_COUNT, c2);
      chk("gate_hold", c2, c1);
      chk("gate_span", 32'(c1 >= 36 && c1 <= 44), 32'h1);
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h7);
      rd_reg(ECC_ADDR_COUNT, c1);
      waitc(20);
      rd_reg(ECC_ADDR_COUNT, c2);
      chk("gate_low", c2 - c1, 32'h16);
      // Until-stop: primary ends; then start-stop from one input
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h202);
      wr_reg(ECC_ADDR_COUNT, 32'h0);
      pin_drv[0] <= 1'b1;
      waitc(10);
      rd_reg(ECC_ADDR_END_CAP, rv);
      chk("until_end", 32'(rv >= 32'h4 && rv <= 32'h6), 32'h1);
      pin_drv[0] <= 1'b0;
      waitc(10);
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h14001);
      pin_drv[0] <= 1'b1;
      waitc(30);
      pin_drv[0] <= 1'b0;
      waitc(10);
      rd_reg(ECC_ADDR_BEGIN_CAP, c1);
      rd_reg(ECC_ADDR_END_CAP, c2);
      chk("single_gap", c2 - c1, 32'h1E);
      // Sync from global wire, from a channel, and disabled
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h0);
      for (int i = 0; i < 3; i++) begin
         pin_drv[2] <= 1'b1;
         wr_reg(ECC_ADDR_SYNC_CFG, sync_tab[i]);
         waitc(100);
         if (i == 1) begin
            pin_drv[2] <= 1'b0;
         end else begin
            wr_reg(ECC_ADDR_GLOBAL_SYNC, 32'h1);
         end
         waitc(10);
         rd_reg(ECC_ADDR_COUNT, rv);
         chk("sync_reset", 32'(rv < 32'h20), 32'(i != 2));
      end
      // Sinking outputs
      pin_drv[5:3] <= 3'b111;
      wr_reg(ECC_ADDR_CHAN_CFG, 32'h43);
      chk("oe_ch3", chan_oe_n, 32'hFFFFFFF7);
      chk("pin_ch3", 32'(chan_in[3]), 32'h0);
      wr_reg(ECC_ADDR_CHAN_CFG, 32'h65);
      rd_reg(ECC_ADDR_CHAN_CFG, rv);
      chk("out_mask", rv, 32'h28);
      wr_reg(ECC_ADDR_OUT_LEVEL, 32'hFFFFFFDF);
      chk("oe_swap", chan_oe_n, 32'hFFFFFFDF);
      wr_reg(ECC_ADDR_OUT_LEVEL, 32'h0);
      chk("oe_only_out", chan_oe_n, 32'hFFFFFFD7);
      rd_reg(ECC_ADDR_STATUS, rv);
      chk("refused", 32'(rv[0]), 32'h1);
      wr_reg(ECC_ADDR_STATUS, 32'h0);
      rd_reg(ECC_ADDR_STATUS, rv);
      chk("refused_clr", 32'(rv[0]), 32'h0);
      // Pending limit, keep flag, wrap and divided clock
      wr_reg(ECC_ADDR_LIMIT, 32'h10);
      rd_reg(ECC_ADDR_STATUS, rv);
      chk("lim_pending", 32'(rv[1]), 32'h1);
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h40000);
      rd_reg(ECC_ADDR_LIMIT, rv);
      chk("lim_kept", rv, 32'h10);
      wr_reg(ECC_ADDR_COUNT, 32'h0);
      rd_reg(ECC_ADDR_STATUS, rv);
      chk("lim_applied", 32'(rv[1]), 32'h0);
      for (int i = 0; i < 8; i++) begin
         waitc(3);
         rd_reg(ECC_ADDR_COUNT, rv);
         chk("wrap", 32'(rv <= 32'h10), 32'h1);
      end
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h0);
      rd_reg(ECC_ADDR_LIMIT, rv);
      chk("lim_reload", rv, 32'hFFFF);
      wr_reg(ECC_ADDR_COUNT, 32'h0);
      wr_reg(ECC_ADDR_PRESCALE, 32'h3);
      wr_reg(ECC_ADDR_CAPTURE_CFG, 32'h20000);
      rd_reg(ECC_ADDR_COUNT, c1);
      waitc(38);
      rd_reg(ECC_ADDR_COUNT, c2);
      chk("divided", c2 - c1, 32'hA);
      complete_run();
   end
endmodule
